// File: rtl/acr_defines.svh
// Register offsets, field positions, reset values for the converter
// configuration and calibration slice. Included by the RTL.
`ifndef ACR_DEFINES_SVH
`define ACR_DEFINES_SVH
`define ACR_OFF_READ_OPT   8'h05
`define ACR_OFF_REF_SEL    8'h06
`define ACR_OFF_OFS_LOW    8'h07
`define ACR_OFF_OFS_MID    8'h08
`define ACR_OFF_OFS_HIGH   8'h09
`define ACR_OFF_GAIN_LOW   8'h0a
`define ACR_OFF_GAIN_MID   8'h0b
`define ACR_OFF_GAIN_HIGH  8'h0c
`define ACR_OFF_SPARE_ONES 8'h0d
`define ACR_OFF_SPARE_ZERO 8'h0e
`define ACR_STAT_INC_BIT   6
`define ACR_RST_READ_OPT   8'h00
`define ACR_RST_REF_SEL    8'h05
`define ACR_RST_OFS        8'h00
`define ACR_RST_GAIN_LOW   8'h00
`define ACR_RST_GAIN_MID   8'h00
`define ACR_RST_GAIN_HIGH  8'h40
`define ACR_RST_SPARE_ONES 8'hff
`define ACR_RST_SPARE_ZERO 8'h00
`define ACR_REF_ANALOG     4'h5
`define ACR_REF_EXTERNAL   4'ha
`define ACR_UNITY_SHIFT    22
`endif

// File: rtl/acr_pkg.sv
// Types shared by the calibration register slice.
// Assumes acr_defines.svh is on the include path.
package acr_pkg;
   // Raw conversion result with its strobe.
   typedef struct packed {
      logic        valid;
      logic [23:0] data;
   } acr_sample_s;
   // Reference source decoded from the selector field.
   typedef enum logic [1:0] {
      ACR_REF_NONE = 2'b00,
      ACR_REF_ANALOG_SUPPLY_REF = 2'b01,
      ACR_REF_EXT  = 2'b10
   } acr_ref_e;
   // Bus slave states, one-hot.
   typedef enum logic [1:0] {
      ACR_IDLE = 2'b01,
      ACR_DONE = 2'b10
   } acr_bus_e;
endpackage

// File: rtl/acr_regs.sv
// Configuration and calibration register slice with result correction.
// Assumes an APB master on pclk and a raw result stream on the same clock.
//
// The implementer's own choice: the APB register port.
`include "acr_defines.svh"

// Function
// R1: Status-include bit 6 appends the status byte to data reads; clear at reset.
// R2: Selector code 0101 picks analog supply (reset), 1010 external reference.
// R3: Host loads only the two defined selector codes; others reserved.
// R4: Offset word is 24-bit signed, three bytes from 07h, low byte first.
// R5: Offset is subtracted first, then gain correction applied.
// R6: Gain word is 24-bit unsigned, three bytes from 0Ah, low byte first.
// R7: Result scaled by gain word over 400000h; 400000h is unity.
// R8: Gain bytes reset to 00h, 00h, 40h low to high.
// R9: Offset bytes reset to zero.
// R10: Filler register at 0Dh is read-only and reads all ones.
// R11: Host writes zeros to reserved bits and ones to the filler.
// R12: Corrected result clamps to the 24-bit signed range on overflow.
module acr_regs (
   // Clock and reset.
   input  wire logic               pclk,
   input  wire logic               presetn,
   // APB slave.
   input  wire logic               psel,
   input  wire logic               penable,
   input  wire logic               pwrite,
   input  wire logic [7:0]         paddr,
   input  wire logic [31:0]        pwdata,
   output logic      [31:0]        prdata,
   output logic                    pready,
   output logic                    pslverr,
   // Conversion path.
   input  wire acr_pkg::acr_sample_s raw_in,
   output acr_pkg::acr_sample_s    corr_out,
   // Configuration outputs.
   output logic                    status_byte_include,
   output acr_pkg::acr_ref_e       reference_source
);
   import acr_pkg::*;

   // ****************************************
   // Register storage
   // ****************************************
   logic [7:0] read_option_cfg_q;
   logic [7:0] reference_select_cfg_q;
   logic [7:0] offset_corr_low_q, offset_corr_mid_q, offset_corr_high_q;
   logic [7:0] gain_corr_low_q, gain_corr_mid_q, gain_corr_high_q;
   logic [7:0] spare_zero_register_q;
   acr_bus_e   bus_q;
   logic       wr_en, rd_hit;
   logic [7:0] rd_byte;

   // Offsets are printed as word indices; byte address is four times.
   function automatic logic [7:0] acr_idx(input logic [7:0] a);
      return {2'b00, a[7:2]};
   endfunction

   // A write lands only at the edge where the master samples pready high,
   // and a misaligned byte address never aliases onto a mapped register.
   assign wr_en = psel && penable && pwrite && pready
                  && paddr[1:0] == 2'b00;

   // Register writes; the filler register ignores writes.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         read_option_cfg_q      <= `ACR_RST_READ_OPT;      // R1
         reference_select_cfg_q <= `ACR_RST_REF_SEL;       // R2
         offset_corr_low_q      <= `ACR_RST_OFS;           // R9
         offset_corr_mid_q      <= `ACR_RST_OFS;
         offset_corr_high_q     <= `ACR_RST_OFS;
         gain_corr_low_q        <= `ACR_RST_GAIN_LOW;      // R8
         gain_corr_mid_q        <= `ACR_RST_GAIN_MID;
         gain_corr_high_q       <= `ACR_RST_GAIN_HIGH;
         spare_zero_register_q  <= `ACR_RST_SPARE_ZERO;
      end else if (wr_en) begin
         case (acr_idx(paddr))
            `ACR_OFF_READ_OPT:  read_option_cfg_q      <= pwdata[7:0];
            `ACR_OFF_REF_SEL:   reference_select_cfg_q <= pwdata[7:0];
            `ACR_OFF_OFS_LOW:   offset_corr_low_q      <= pwdata[7:0];
            `ACR_OFF_OFS_MID:   offset_corr_mid_q      <= pwdata[7:0];
            `ACR_OFF_OFS_HIGH:  offset_corr_high_q     <= pwdata[7:0];
            `ACR_OFF_GAIN_LOW:  gain_corr_low_q        <= pwdata[7:0];
            `ACR_OFF_GAIN_MID:  gain_corr_mid_q        <= pwdata[7:0];
            `ACR_OFF_GAIN_HIGH: gain_corr_high_q       <= pwdata[7:0];
            `ACR_OFF_SPARE_ZERO: spare_zero_register_q <= pwdata[7:0];
            default: ;
         endcase
      end
   end

   // Read mux; unmapped addresses read zero and raise pslverr.
   always_comb begin
      rd_hit  = 1'b1;
      rd_byte = 8'h00;
      case (acr_idx(paddr))
         `ACR_OFF_READ_OPT:   rd_byte = read_option_cfg_q;
         `ACR_OFF_REF_SEL:    rd_byte = reference_select_cfg_q;
         `ACR_OFF_OFS_LOW:    rd_byte = offset_corr_low_q;
         `ACR_OFF_OFS_MID:    rd_byte = offset_corr_mid_q;
         `ACR_OFF_OFS_HIGH:   rd_byte = offset_corr_high_q;
         `ACR_OFF_GAIN_LOW:   rd_byte = gain_corr_low_q;
         `ACR_OFF_GAIN_MID:   rd_byte = gain_corr_mid_q;
         `ACR_OFF_GAIN_HIGH:  rd_byte = gain_corr_high_q;
         `ACR_OFF_SPARE_ONES: rd_byte = `ACR_RST_SPARE_ONES; // R10
         `ACR_OFF_SPARE_ZERO: rd_byte = spare_zero_register_q;
         default:             rd_hit  = 1'b0;
      endcase
      if (paddr[1:0] != 2'b00) begin
         rd_hit = 1'b0;
      end
   end

   // ****************************************
   // APB handshake
   // ****************************************
   // One wait state: pready rises the cycle after the access phase starts,
   // so read data and pready both come straight from flip-flops.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         bus_q   <= ACR_IDLE;
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= 32'h0000_0000;
      end else begin
         case (bus_q)
            ACR_IDLE: begin
               if (psel && penable) begin
                  bus_q   <= ACR_DONE;
                  pready  <= 1'b1;
                  pslverr <= !rd_hit;
                  prdata  <= (pwrite || !rd_hit) ? 32'h0000_0000
                                                 : {24'h00_0000, rd_byte};
               end
            end
            ACR_DONE: begin
               bus_q   <= ACR_IDLE;
               pready  <= 1'b0;
               pslverr <= 1'b0;
               prdata  <= 32'h0000_0000;
            end
            default: bus_q <= ACR_IDLE;
         endcase
      end
   end

   // ****************************************
   // Configuration decode
   // ****************************************
   // Reserved selector codes map to NONE so the analog side can flag them.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         status_byte_include <= 1'b0;
         reference_source    <= ACR_REF_ANALOG_SUPPLY_REF;
      end else begin
         status_byte_include <= read_option_cfg_q[`ACR_STAT_INC_BIT]; // R1
         case (reference_select_cfg_q[3:0])                           // R2
            `ACR_REF_ANALOG:   reference_source <= ACR_REF_ANALOG_SUPPLY_REF;
            `ACR_REF_EXTERNAL: reference_source <= ACR_REF_EXT;
            default:           reference_source <= ACR_REF_NONE;       // R3
         endcase
      end
   end

   // ****************************************
   // Result correction
   // ****************************************
   logic signed [23:0] offset_correction_word;
   logic        [23:0] gain_correction_word;
   logic signed [24:0] diff_d, diff_q;
   logic signed [23:0] diff_sat;
   logic signed [49:0] prod;
   logic signed [27:0] scaled;
   logic               stage1_q;

   // Saturate a 28-bit signed value into 24 bits.
   function automatic logic signed [23:0] acr_clamp(
      input logic signed [27:0] v);
      if (v > 28'sh07f_ffff) begin
         return 24'sh7f_ffff;
      end else if (v < -28'sh080_0000) begin
         return 24'sh80_0000;
      end
      return v[23:0];
   endfunction

   assign offset_correction_word = {offset_corr_high_q, offset_corr_mid_q,
                                    offset_corr_low_q};        // R4
   assign gain_correction_word   = {gain_corr_high_q, gain_corr_mid_q,
                                    gain_corr_low_q};          // R6
   assign diff_d   = {raw_in.data[23], raw_in.data}
                   - {offset_correction_word[23], offset_correction_word};
   assign diff_sat = acr_clamp({{3{diff_q[24]}}, diff_q});       // R12
   assign prod     = diff_sat * $signed({2'b00, gain_correction_word});
   assign scaled   = prod[49:22] >>> 0;                          // R7

   // Stage one subtracts the offset, stage two applies the gain.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         diff_q   <= '0;
         stage1_q <= 1'b0;
      end else begin
         diff_q   <= diff_d;                                     // R5
         stage1_q <= raw_in.valid;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         corr_out <= '0;
      end else begin
         corr_out.valid <= stage1_q;
         corr_out.data  <= acr_clamp(scaled);                    // R5
      end
   end

   // ****************************************
   // Checks
   // ****************************************
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   sequence acr_setup_s;
      psel && !penable;
   endsequence
   sequence acr_access_s;
      psel && penable && !pready;
   endsequence

   apb_answer_a: assert property (acr_setup_s ##1 acr_access_s |=> pready)
      else $error("pready not one cycle after access");
   stat_include_a: assert property (status_byte_include ==
      $past(read_option_cfg_q[6])) else $error("status include lag"); // R1
   ref_decode_a: assert property ($past(reference_select_cfg_q[3:0]) == 4'ha
      |-> reference_source == ACR_REF_EXT) else $error("ref decode"); // R2
   ref_reserved_a: assert property ($past(reference_select_cfg_q[3:0]) != 4'h5
      && $past(reference_select_cfg_q[3:0]) != 4'ha
      |-> reference_source == ACR_REF_NONE) else $error("ref rsvd"); // R3
   filler_read_a: assert property (pready && !pslverr && $past(!pwrite)
      && $past(paddr) == 8'h34 |-> prdata == 32'hff) else $error("filler"); // R10
   unity_gain_a: assert property (gain_correction_word == 24'h40_0000
      && $stable(gain_correction_word) && $past(stage1_q)
      |-> corr_out.data == $past(diff_sat)) else $error("unity"); // R7
   offset_sub_a: assert property (stage1_q && !diff_q[24] && !diff_q[23]
      |-> diff_q == $past(diff_d)) else $error("offset sub"); // R4
   gain_order_a: assert property (raw_in.valid |-> ##2 corr_out.valid)
      else $error("valid latency"); // R5
   clamp_range_a: assert property (stage1_q && diff_q > 25'sh07f_ffff
      |-> diff_sat == 24'sh7f_ffff) else $error("clamp"); // R12
   gain_word_a: assert property (psel && penable && pwrite && pready
      && paddr == 8'h28 |=> gain_correction_word[7:0] == $past(pwdata[7:0]))
      else $error("gain word"); // R6
   reset_vals_a: assert property ($rose(presetn) |-> offset_corr_low_q == 8'h00
      && gain_corr_high_q == 8'h40) else $error("reset values"); // R8
   ofs_reset_a: assert property ($rose(presetn) |-> offset_corr_high_q == 8'h00
      && offset_corr_mid_q == 8'h00) else $error("offset reset"); // R9

   // ****************************************
   // Bus protocol checks
   // ****************************************
   // The answer is a one-cycle pulse; a stuck pready would let the master
   // run a second transfer into the first.
   sequence acr_answer_s;
      psel && penable && pready;
   endsequence

   ready_pulse_a: assert property (pready |=> !pready)
      else $error("pready longer than one cycle");
   slverr_with_a: assert property (pslverr |-> pready)
      else $error("pslverr without pready");
   rdata_idle_a: assert property (!pready |-> prdata == 32'h0000_0000)
      else $error("prdata outside answer");
   misalign_err_a: assert property (psel && penable && !pready
      && paddr[1:0] != 2'b00 |=> pslverr)
      else $error("misaligned access not refused");
   // Misaligned writes must leave the option, selector, offset and gain registers alone.
   misalign_wr_a: assert property (acr_answer_s ##0 pwrite
      && paddr[1:0] != 2'b00 |=> $stable({read_option_cfg_q,
      reference_select_cfg_q, offset_correction_word,
      gain_correction_word})) else $error("misaligned write landed");
   // The read option register at 14h may not change before the answer edge.
   early_write_a: assert property (psel && penable && pwrite && !pready
      && paddr == 8'h14 |=> $stable(read_option_cfg_q))
      else $error("write before answer");

   // ****************************************
   // Register write checks
   // ****************************************
   ref_write_a: assert property (acr_answer_s ##0 pwrite
      && paddr == 8'h18 |=> reference_select_cfg_q == $past(pwdata[7:0]))
      else $error("reference write"); // R2
   ofs_write_a: assert property (acr_answer_s ##0 pwrite
      && paddr == 8'h1c |=> offset_correction_word[7:0] ==
      $past(pwdata[7:0])) else $error("offset write"); // R4
   filler_keep_a: assert property (acr_answer_s ##0 pwrite
      && paddr == 8'h34 |=> !pslverr) else $error("filler write"); // R10

   // ****************************************
   // Correction path checks
   // ****************************************
   // Negative overflow must pin to the most negative code, not wrap.
   clamp_low_a: assert property (stage1_q && diff_q < -25'sh080_0000
      |-> diff_sat == 24'sh80_0000) else $error("clamp low"); // R12
   valid_src_a: assert property (corr_out.valid |-> $past(stage1_q))
      else $error("spurious valid"); // R5
endmodule // acr_regs

// File: testbench/acr_host.sv
// APB host model that reaches the calibration register slice.
// Assumes one pclk domain; the bench calls xfer just after an edge.
module acr_host (
   // Clock.
   input  wire logic        pclk,
   // APB master side.
   output logic             psel,
   output logic             penable,
   output logic             pwrite,
   output logic [7:0]       paddr,
   output logic [31:0]      pwdata,
   input  wire logic [31:0] prdata,
   input  wire logic        pready,
   input  wire logic        pslverr
);
   timeunit 1ns;
   timeprecision 1ns;
   // ****************************************
   // Bus transfer
   // ****************************************
   // Idle bus at time zero.
   initial begin
      psel    = 1'b0;
      penable = 1'b0;
      pwrite  = 1'b0;
      paddr   = 8'h00;
      pwdata  = 32'h00000000;
   end
   // One transfer; the request is held until pready is seen at an edge.
   // The leading edge keeps two transfers from colliding in one step.
   task automatic xfer(input logic w, input logic [7:0] a, d,
                       output logic [7:0] rd,
                       output logic err, hung);
      int n;
      n = 0;
      @(posedge pclk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= {24'h000000, d};
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 16);
      hung = (pready !== 1'b1);
      rd = prdata[7:0];
      err = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
      paddr   <= ~a;
      pwdata  <= ~{24'h000000, d};
   endtask
endmodule // acr_host

// File: testbench/acr_regs_tb.sv
// Self-checking bench for the calibration register slice.
// Assumes acr_pkg is compiled first and acr_host drives the APB side.
module acr_regs_tb;
   timeunit 1ns;
   timeprecision 1ns;
   import acr_pkg::*;
   // ****************************************
   // Signals and helpers
   // ****************************************
   typedef struct packed {
      logic [7:0] a;
      logic [7:0] d;
      logic [7:0] q;
      logic       e;
   } acr_row_s;
   logic pclk = 1'b0, presetn = 1'b0, psel, penable, pwrite;
   logic pready, pslverr, status_byte_include;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata;
   acr_sample_s raw_in = '0, corr_out;
   acr_ref_e reference_source;
   int failures = 0, check_count = 0;
   acr_row_s rows [11] = '{'{8'h14,8'h40,8'h40,0}, '{8'h18,8'h0a,8'h0a,0},
      '{8'h1c,8'ha5,8'ha5,0}, '{8'h20,8'h5a,8'h5a,0}, '{8'h24,8'h81,8'h81,0},
      '{8'h28,8'h12,8'h12,0}, '{8'h2c,8'h34,8'h34,0}, '{8'h30,8'h7f,8'h7f,0},
      '{8'h34,8'hff,8'hff,0}, '{8'h3c,8'h77,8'h00,1}, '{8'h15,8'h77,8'h00,1}};
   logic [7:0] rst_val [10] = '{8'h00, 8'h05, 8'h00, 8'h00, 8'h00,
                               8'h00, 8'h00, 8'h40, 8'hff, 8'h00};
   logic [71:0] cases [6] = '{{24'h0, 24'h400000, 24'h123456},
      {24'h10, 24'h800000, 24'h100}, {24'hffffff, 24'h400000, 24'h7fffff},
      {24'h0, 24'h800000, 24'h900000}, {24'h0, 24'h200000, 24'h3},
      {24'h0, 24'h200000, 24'hfffffd}};
   logic [7:0] rd;
   logic e;
   int n;
   // Clock at 25 MHz.
   always #20 pclk = ~pclk;
   acr_host HOST (.pclk(pclk), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr));
   acr_regs DUT (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .raw_in(raw_in),
      .corr_out(corr_out), .status_byte_include(status_byte_include),
      .reference_source(reference_source));
   // Saturation to the signed 24-bit range.
   function automatic longint sat(input longint v);
      return (v > 8388607) ? 8388607 : ((v < -8388608) ? -8388608 : v);
   endfunction
   // Offset first, then gain over 400000h with flooring.
   function automatic logic [23:0] model(input logic [23:0] r, o, g);
      longint s;
      s = sat(longint'($signed(r)) - longint'($signed(o)));
      return 24'(sat((s * longint'(g)) >>> 22));
   endfunction
   task automatic check(input string what, input logic [31:0] seen, exp);
      check_count++;
      if (seen !== exp) begin
         failures++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic final_report();
      $display("checks %0d failures %0d", check_count, failures);
      if (failures == 0 && check_count > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   // A hung bus ends the run at once.
   task automatic rw(input logic w, input logic [7:0] a, d);
      logic hung;
      HOST.xfer(w, a, d, rd, e, hung);
      if (hung) begin
         failures++;
         final_report();
      end
   endtask
   task automatic wr_word(input logic [7:0] a, input logic [23:0] v);
      for (int i = 0; i < 3; i++) rw(1'b1, a + 8'(4 * i), v[8 * i +: 8]);
   endtask
   task automatic reset_check();
      check("include", status_byte_include, 0);
      check("ref", reference_source, ACR_REF_ANALOG_SUPPLY_REF);
      for (int i = 0; i < 10; i++) begin
         rw(1'b0, 8'((5 + i) * 4), 8'h00);
         check("reset value", rd, rst_val[i]);
      end
   endtask
   // ****************************************
   // Main sequence
   // ****************************************
   initial begin
      repeat (12) @(posedge pclk);
      presetn <= 1'b1;
      reset_check();
      $display("test reset done");
      foreach (rows[i]) begin
         rw(1'b1, rows[i].a, rows[i].d);
         check("write err", e, rows[i].e);
         rw(1'b0, rows[i].a, 8'h00);
         check("readback", rd, rows[i].q);
         check("read err", e, rows[i].e);
      end
      check("include", status_byte_include, 1);
      check("ref", reference_source, ACR_REF_EXT);
      $display("test registers done");
      foreach (cases[i]) begin
         wr_word(8'h1c, cases[i][71:48]);
         wr_word(8'h28, cases[i][47:24]);
         raw_in <= '{valid: 1'b1, data: cases[i][23:0]};
         @(posedge pclk);
         raw_in <= '{valid: 1'b0, data: ~cases[i][23:0]};
         n = 1;
         do begin
            @(posedge pclk);
            #1;
            n++;
         end while (corr_out.valid !== 1'b1 && n < 8);
         check("latency", n, 2);
         check("result", corr_out.data, model(cases[i][23:0],
               cases[i][71:48], cases[i][47:24]));
      end
      $display("test correction done");
      rw(1'b1, 8'h18, 8'h05);
      rw(1'b1, 8'h14, 8'h00);
      repeat (2) @(posedge pclk);
      check("ref", reference_source, ACR_REF_ANALOG_SUPPLY_REF);
      check("include", status_byte_include, 0);
      rw(1'b1, 8'h30, 8'h7f);
      presetn <= 1'b0;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      reset_check();
      $display("test mid-run reset done");
      final_report();
   end
endmodule // acr_regs_tb
